/* design/sram_port_pkg.sv */
// Operation
// - Every pending read and write finishes before the clock-stopped state is entered, and the data outputs hold their state while stopped.
//   Here idle ignores a command accepted in the same cycle, so that command still runs after the stop is entered.
// - Load-select high at a K rise is a no-operation, the read/write select is ignored and the data outputs stay high impedance.
// - A read taken at edge t drives word one at t+1, words two and three at t+2 and word four at t+3.
// - Lane strobes count only inside an initiated write, and every beat carries its own lane mask.
// - On the 18-bit variant a low strobe writes its byte, both low write both, both high write nothing.
// - On the 36-bit variant all strobes low write every byte, strobe 0 alone writes byte 0 and strobe 1 alone writes byte 1.
// - On the 36-bit variant strobes 2 and 3 low write bytes 2 and 3, and all strobes high write nothing.
// - Each strobe governs one nine-bit lane, strobe n covering bits 9n to 9n+8.
// - Each command moves four words, the two low address bits advancing in linear wrapping order from the given address.
// - With the output clock pair held high, read data launch from the K edges instead of the output clock edges.
package sram_port_pkg;
    localparam int WORD_W      = 36;
    localparam int LANE_W      = 9;
    localparam int LANES       = WORD_W / LANE_W;
    localparam int ADDR_W      = 21;
    localparam int COL_W       = 2;
    localparam int ROW_W       = ADDR_W - COL_W;
    localparam int BURST_LEN   = 4;
    localparam int FIFO_DEPTH  = 32;
    localparam logic [1:0] PH_IDLE = 2'h0;
    localparam logic [1:0] PH_ONE  = 2'h1;
    localparam logic [1:0] PH_TWO  = 2'h2;
    localparam logic [1:0] PH_THREE = 2'h3;

    typedef logic [WORD_W-1:0] word_t;
    typedef logic [LANES-1:0]  lanes_t;

    // one half of a write burst: two beats bound for adjacent columns
    typedef struct packed {
        logic [ROW_W-1:0]  row;
        logic [COL_W-1:0]  col;
        logic [1:0][WORD_W-1:0] data;
        logic [1:0][LANES-1:0]  laneEn;
    } wr_pair_t;

    // pin image that passes the input synchroniser
    typedef struct packed {
        logic              loadSelectN;
        logic              readWriteSel;
        logic [ADDR_W-1:0] addr;
        logic [1:0][WORD_W-1:0] dq;
        logic [1:0][LANES-1:0]  strobeN;
        logic              clkStopReq;
    } pins_t;

    function automatic logic [COL_W-1:0] burstCol(input logic [COL_W-1:0] start,
                                                 input logic [COL_W-1:0] step);
        burstCol = start + step;
    endfunction : burstCol

    function automatic lanes_t laneDecode(input lanes_t strobeN);
        laneDecode = ~strobeN;
    endfunction : laneDecode
endpackage : sram_port_pkg

/* design/sram_storage.sv */
`timescale 1ns/1ps
module burst_store
    import sram_port_pkg::*;
#(
    parameter int ROWS_W = ROW_W
) (
    input  wire logic                          clk,
    input  wire logic                          rdEn,
    input  wire logic [ROWS_W-1:0]             rdRow,
    output logic      [BURST_LEN-1:0][WORD_W-1:0] rdData,
    input  wire logic                          wrEn,
    input  wire logic [ROWS_W-1:0]             wrRow,
    input  wire logic [BURST_LEN-1:0][WORD_W-1:0] wrData,
    input  wire logic [BURST_LEN-1:0][LANES-1:0]  wrLaneEn
);
    logic [BURST_LEN-1:0][WORD_W-1:0] mem [0:(1<<ROWS_W)-1];

    always_ff @(posedge clk) begin
        if (rdEn) begin
            rdData <= mem[rdRow];
        end
    end

    always_ff @(posedge clk) begin
        if (wrEn) begin
            for (int w = 0; w < BURST_LEN; w++) begin
                for (int l = 0; l < LANES; l++) begin
                    if (wrLaneEn[w][l]) begin
                        mem[wrRow][w][l*LANE_W +: LANE_W] <= wrData[w][l*LANE_W +: LANE_W];
                    end
                end
            end
        end
    end
endmodule : burst_store

module word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rstN,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int PTR_W = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << PTR_W) != DEPTH) begin : g_depthCheck
        $error("fifo depth must be a power of two");
    end
    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [PTR_W-1:0] rdPtr_q;
    logic [PTR_W-1:0] wrPtr_q;
    logic [PTR_W:0]   count_q;
    logic             push;
    logic             pop;

    assign inReady  = (count_q != DEPTH[PTR_W:0]);
    assign outValid = (count_q != '0);
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;
    assign outData  = store[rdPtr_q];

    always_ff @(posedge clk) begin
        if (push) begin
            store[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            rdPtr_q <= '0;
            wrPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) wrPtr_q <= wrPtr_q + 1'b1;
            if (pop)  rdPtr_q <= rdPtr_q + 1'b1;
            count_q <= count_q + {{PTR_W{1'b0}}, push} - {{PTR_W{1'b0}}, pop};
        end
    end
endmodule : word_fifo

/* design/burst4_common_io_sram_port.sv */
`timescale 1ns/1ps
module burst4_common_io_sram_port
    import sram_port_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic                   sys_clk,
    input  wire logic                   resetn,
    input  wire logic                   loadSelectN,
    input  wire logic                   readWriteSel,
    input  wire logic [ADDR_W-1:0]      addr,
    input  wire logic [1:0][WORD_W-1:0] dqIn,
    input  wire logic [1:0][LANES-1:0]  laneWriteStrobeN,
    input  wire logic                   clkStopReq,
    output logic      [1:0][WORD_W-1:0] dqOut,
    output logic                        dqOeN,
    output logic                        writeReady,
    output logic                        stopReady
);
    // refuse shapes the lane decoder and the write queue cannot serve
    if (LANES * LANE_W != WORD_W) begin : g_laneCheck
        $error("word width must be whole nine-bit lanes");
    end
    // a burst pushes two pairs, so fewer than four slots would stall back to back writes
    if (DEPTH < 4) begin : g_depthCheck
        $error("write fifo too shallow");
    end

    localparam pins_t PINS_RESET = '{loadSelectN: 1'b1, readWriteSel: 1'b0, addr: '0,
                                     dq: '0, strobeN: '1, clkStopReq: 1'b0};

    // every pin crosses two flops; the first stage feeds only the second
    // limitation: the whole pin image is delayed by two cycles, so the
    // controller sees read data two cycles later than on a bare device
    pins_t pinMeta_q;
    pins_t pin_q;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pinMeta_q <= PINS_RESET;
            pin_q     <= PINS_RESET;
        end else begin
            pinMeta_q <= '{loadSelectN: loadSelectN, readWriteSel: readWriteSel, addr: addr,
                           dq: dqIn, strobeN: laneWriteStrobeN, clkStopReq: clkStopReq};
            pin_q     <= pinMeta_q;
        end
    end

    logic       busy_q;
    logic       stopped_q;
    logic [1:0] rdPhase_q;
    logic [1:0] wrPhase_q;
    logic [COL_W-1:0] rdCol_q;
    logic [COL_W-1:0] wrCol_q;
    logic [ROW_W-1:0] wrRow_q;
    logic       accept;
    logic       rdIssue;
    logic       wrIssue;
    logic       idle;

    // a burst takes two cycles, so the slot right after an accepted command is ignored
    // trade-off: a refused slot is dropped silently rather than flagged, since the
    // pin interface has no way to report it back to the controller
    assign accept  = !pin_q.loadSelectN && !busy_q && !stopped_q;
    assign rdIssue = accept && pin_q.readWriteSel;
    assign wrIssue = accept && !pin_q.readWriteSel;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= accept;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rdPhase_q <= PH_IDLE;
            rdCol_q   <= '0;
        end else if (rdIssue) begin
            rdPhase_q <= PH_ONE;
            rdCol_q   <= pin_q.addr[COL_W-1:0];
        end else if (rdPhase_q != PH_IDLE) begin
            rdPhase_q <= (rdPhase_q == PH_THREE) ? PH_IDLE : rdPhase_q + 2'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wrPhase_q <= PH_IDLE;
            wrCol_q   <= '0;
            wrRow_q   <= '0;
        end else if (wrIssue) begin
            wrPhase_q <= PH_ONE;
            wrCol_q   <= pin_q.addr[COL_W-1:0];
            wrRow_q   <= pin_q.addr[ADDR_W-1:COL_W];
        end else if (wrPhase_q == PH_ONE) begin
            wrPhase_q <= PH_TWO;
        end else begin
            wrPhase_q <= PH_IDLE;
        end
    end

    // write beats: strobes are looked at only while a write burst is in flight
    // phase one carries columns s and s+1, phase two columns s+2 and s+3
    wr_pair_t pairIn;
    wr_pair_t pairOut;
    logic     pairValid;
    logic     drainValid;
    logic     drainReady;
    assign pairValid = (wrPhase_q != PH_IDLE);
    always_comb begin
        pairIn.row = wrRow_q;
        pairIn.col = (wrPhase_q == PH_TWO) ? burstCol(wrCol_q, 2'h2) : wrCol_q;
        pairIn.data = pin_q.dq;
        for (int b = 0; b < 2; b++) begin
            pairIn.laneEn[b] = laneDecode(pin_q.strobeN[b]);
        end
    end

    // the fifo absorbs writes while reads hold the store; writeReady warns of overflow
    // hazard: a read of a row whose write still sits in the queue sees the old word
    assign drainReady = !rdIssue;
    word_fifo #(
        .WIDTH ($bits(wr_pair_t)),
        .DEPTH (DEPTH)
    ) u_wrFifo (
        .clk      (sys_clk),
        .rstN     (resetn),
        .inValid  (pairValid),
        .inReady  (writeReady),
        .inData   (pairIn),
        .outValid (drainValid),
        .outReady (drainReady),
        .outData  (pairOut)
    );

    logic [BURST_LEN-1:0][WORD_W-1:0] memWrData;
    logic [BURST_LEN-1:0][LANES-1:0]  memWrLaneEn;
    logic [BURST_LEN-1:0][WORD_W-1:0] memRdData;
    // a pair touches two of the four words; the others keep their lanes disabled
    always_comb begin
        memWrData   = '0;
        memWrLaneEn = '0;
        for (int b = 0; b < 2; b++) begin
            memWrData[burstCol(pairOut.col, 2'(b))]   = pairOut.data[b];
            memWrLaneEn[burstCol(pairOut.col, 2'(b))] = pairOut.laneEn[b];
        end
    end

    burst_store #(
        .ROWS_W (ROW_W)
    ) u_store (
        .clk      (sys_clk),
        .rdEn     (rdIssue),
        .rdRow    (pin_q.addr[ADDR_W-1:COL_W]),
        .rdData   (memRdData),
        .wrEn     (drainValid && drainReady),
        .wrRow    (pairOut.row),
        .wrData   (memWrData),
        .wrLaneEn (memWrLaneEn)
    );

    // both slots launch from sys_clk, which stands for K here, so the
    // tied-high output clock case and the normal case share one timing
    always_comb begin
        dqOeN = 1'b1;
        dqOut = '0;
        case (rdPhase_q)
            PH_ONE: begin
                dqOeN    = 1'b0;
                dqOut[0] = memRdData[rdCol_q];
                dqOut[1] = memRdData[rdCol_q];
            end
            PH_TWO: begin
                dqOeN    = 1'b0;
                dqOut[0] = memRdData[burstCol(rdCol_q, 2'h1)];
                dqOut[1] = memRdData[burstCol(rdCol_q, 2'h2)];
            end
            PH_THREE: begin
                dqOeN    = 1'b0;
                dqOut[0] = memRdData[burstCol(rdCol_q, 2'h3)];
                dqOut[1] = memRdData[burstCol(rdCol_q, 2'h3)];
            end
            default: begin
                dqOeN = 1'b1;
                dqOut = '0;
            end
        endcase
    end

    // stopping waits for reads, write beats and queued writes already in flight, but not for a command accepted in the stop cycle
    // while stopped, commands are refused and the data bus stays released, except for a read accepted in the cycle the stop is entered
    assign idle = !busy_q && (rdPhase_q == PH_IDLE) && (wrPhase_q == PH_IDLE) && !drainValid;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            stopped_q <= 1'b0;
        end else begin
            stopped_q <= pin_q.clkStopReq && (stopped_q || idle);
        end
    end
    assign stopReady = stopped_q;
endmodule : burst4_common_io_sram_port

/* bench/sram_port_monitor.sv */
`timescale 1ns/1ps
module sram_port_monitor
    import sram_port_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic                   sys_clk,
    input wire logic                   resetn,
    input wire logic                   loadSelectN,
    input wire logic                   readWriteSel,
    input wire logic [ADDR_W-1:0]      addr,
    input wire logic [1:0][WORD_W-1:0] dqIn,
    input wire logic [1:0][LANES-1:0]  laneWriteStrobeN,
    input wire logic                   clkStopReq,
    input wire logic [1:0][WORD_W-1:0] dqOut,
    input wire logic                   dqOeN,
    input wire logic                   writeReady,
    input wire logic                   stopReady
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // a command that no earlier command can mask, with no stop requested or granted in its own cycle
    sequence cmdOk;
        !loadSelectN && $past(loadSelectN) && $past(loadSelectN, 2)
            && $past(loadSelectN, 3) && !clkStopReq && !stopReady;
    endsequence
    sequence rdCmd;
        cmdOk ##0 readWriteSel;
    endsequence
    sequence wrCmd;
        cmdOk ##0 !readWriteSel;
    endsequence

    AST_NOP: assert property (loadSelectN [*6] |-> dqOeN)
        else $error("bus driven with no read");
    AST_IDLE_ZERO: assert property (dqOeN |-> dqOut == '0)
        else $error("idle data not zero");
    AST_RD_LAT: assert property (rdCmd |-> ##2 dqOeN)
        else $error("read data too early");
    AST_RD_BURST: assert property (rdCmd ##1 loadSelectN [*3] |-> !dqOeN [*3] ##1 dqOeN)
        else $error("read burst not three cycles");
    AST_WR_QUIET: assert property (wrCmd ##1 loadSelectN [*2] |-> ##1 dqOeN [*3])
        else $error("bus driven during write");
    AST_STOP_IDLE: assert property (stopReady |-> dqOeN)
        else $error("bus driven while stopped");
    AST_STOP_RISE: assert property ($rose(stopReady) |-> $past(clkStopReq)
        && $past(clkStopReq, 2) && $past(clkStopReq, 3))
        else $error("stop granted too early");
    AST_STOP_WAIT: assert property (cmdOk |-> !stopReady [*6])
        else $error("stop granted with work pending");
    AST_STOP_FALL: assert property ($fell(clkStopReq) |-> ##[1:4] !stopReady)
        else $error("stop grant kept");
endmodule : sram_port_monitor

bind burst4_common_io_sram_port sram_port_monitor #(.DEPTH(DEPTH)) u_mon (
    .sys_clk(sys_clk), .resetn(resetn), .loadSelectN(loadSelectN),
    .readWriteSel(readWriteSel), .addr(addr), .dqIn(dqIn),
    .laneWriteStrobeN(laneWriteStrobeN), .clkStopReq(clkStopReq), .dqOut(dqOut),
    .dqOeN(dqOeN), .writeReady(writeReady), .stopReady(stopReady));

/* bench/sram_ctrl_model.sv */
`timescale 1ns/1ps
module sram_ctrl_model
    import sram_port_pkg::*;
(
    input  wire logic                   sys_clk,
    output logic                        loadSelectN,
    output logic                        readWriteSel,
    output logic      [ADDR_W-1:0]      addr,
    output logic      [1:0][WORD_W-1:0] dqIn,
    output logic      [1:0][LANES-1:0]  laneWriteStrobeN
);
    initial begin
        loadSelectN = 1'b1;
        readWriteSel = 1'b0;
        addr = '0;
        dqIn = '0;
        laneWriteStrobeN = '1;
    end

    // released lines show the inverse of their last value, except that the strobes are driven all low during a read
    task automatic issue(input logic rd, input logic [ADDR_W-1:0] a,
                         input logic [3:0][WORD_W-1:0] w, input logic [3:0][LANES-1:0] m);
        @(posedge sys_clk);
        loadSelectN <= 1'b0;
        readWriteSel <= rd;
        addr <= a;
        @(posedge sys_clk);
        loadSelectN <= 1'b1;
        readWriteSel <= ~rd;
        addr <= ~a;
        dqIn <= rd ? ~dqIn : w[1:0];
        laneWriteStrobeN <= rd ? '0 : m[1:0];
        @(posedge sys_clk);
        dqIn <= rd ? ~dqIn : w[3:2];
        laneWriteStrobeN <= rd ? '0 : m[3:2];
        @(posedge sys_clk);
        dqIn <= ~dqIn;
        laneWriteStrobeN <= ~laneWriteStrobeN;
    endtask : issue
endmodule : sram_ctrl_model

/* bench/burst4_common_io_sram_port_tb.sv */
`timescale 1ns/1ps
module burst4_common_io_sram_port_tb
    import sram_port_pkg::*;
();
    logic                   sys_clk = 1'b0;
    logic                   resetn = 1'b0;
    logic                   clkStopReq = 1'b0;
    logic                   loadSelectN, readWriteSel, dqOeN, writeReady, stopReady;
    logic [ADDR_W-1:0]      addr;
    logic [1:0][WORD_W-1:0] dqIn, dqOut;
    logic [1:0][LANES-1:0]  laneWriteStrobeN;
    logic [3:0][WORD_W-1:0] wd;
    logic [3:0][LANES-1:0]  wm;
    logic [31:0]            rng = 32'ha8e4;
    logic [ROW_W-1:0]       row;
    word_t                  mem [4];
    lanes_t                 maskTab [5] = '{4'h0, 4'he, 4'hd, 4'h3, 4'hf};
    int                     num_errors = 0;
    int                     n_checks = 0;

    always #20 sys_clk = ~sys_clk;

    sram_ctrl_model ctrl (.sys_clk(sys_clk), .loadSelectN(loadSelectN),
        .readWriteSel(readWriteSel), .addr(addr), .dqIn(dqIn),
        .laneWriteStrobeN(laneWriteStrobeN));
    burst4_common_io_sram_port dut (.sys_clk(sys_clk), .resetn(resetn),
        .loadSelectN(loadSelectN), .readWriteSel(readWriteSel), .addr(addr), .dqIn(dqIn),
        .laneWriteStrobeN(laneWriteStrobeN), .clkStopReq(clkStopReq), .dqOut(dqOut),
        .dqOeN(dqOeN), .writeReady(writeReady), .stopReady(stopReady));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // lanes whose strobe is low take the new byte
    function automatic word_t merge(input word_t old, input word_t nw, input lanes_t sN);
        merge = old;
        for (int i = 0; i < LANES; i++) begin
            if (!sN[i]) merge[i*LANE_W +: LANE_W] = nw[i*LANE_W +: LANE_W];
        end
    endfunction : merge

    task automatic check(input string what, input logic [WORD_W-1:0] seen,
                         input logic [WORD_W-1:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude

    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic rdBurst(input logic [COL_W-1:0] s);
        ctrl.issue(1'b1, {row, s}, wd, wm);
        #1;
        check("read start", dqOeN, 1'b0);
        check("word one", dqOut[1], mem[s]);
        check("word one low slot", dqOut[0], mem[s]);
        tick();
        check("word two", dqOut[0], mem[s + 2'h1]);
        check("word three", dqOut[1], mem[s + 2'h2]);
        tick();
        check("word four", dqOut[0], mem[s + 2'h3]);
        check("word four high slot", dqOut[1], mem[s + 2'h3]);
        tick();
        check("read end", dqOeN, 1'b1);
    endtask : rdBurst

    // stop may be requested while the write is still queued
    task automatic wrBurst(input logic [COL_W-1:0] s, input logic stop);
        ctrl.issue(1'b0, {row, s}, wd, wm);
        if (stop) clkStopReq <= 1'b1;
        for (int b = 0; b < 4; b++) begin
            mem[s + COL_W'(b)] = merge(mem[s + COL_W'(b)], wd[b], wm[b]);
        end
        repeat (8) tick();
    endtask : wrBurst

    initial begin
        repeat (2) @(posedge sys_clk);
        check("oe in reset", dqOeN, 1'b1);
        resetn <= 1'b1;
        row = rng[ROW_W-1:0];
        for (int k = 0; k < 14; k++) begin
            for (int b = 0; b < 4; b++) begin
                rng = lfsr(rng);
                wd[b] = {rng[7:4], rng};
                wm[b] = (k == 0) ? 4'h0 : ((k + b) % 6 == 5) ? rng[3:0] : maskTab[(k + b) % 6];
            end
            check("fifo ready", writeReady, 1'b1);
            wrBurst(rng[1:0], 1'b0);
            rdBurst(rng[9:8]);
            $display("test %0d done", k);
        end
        wm = '0;
        wrBurst(2'h1, 1'b1);
        for (int n = 0; n < 20 && stopReady !== 1'b1; n++) tick();
        check("stop grant", stopReady, 1'b1);
        check("stopped bus idle", dqOeN, 1'b1);
        @(posedge sys_clk);
        clkStopReq <= 1'b0;
        repeat (6) tick();
        check("stop released", stopReady, 1'b0);
        rdBurst(2'h1);
        $display("test stop done");
        conclude();
    end
endmodule : burst4_common_io_sram_port_tb
